// ==== fem_regs.svh ====
// Fixed constants of the fast Ethernet transmit MAC and its coding path.
`ifndef FEM_REGS_SVH
`define FEM_REGS_SVH
`define CLK_PERIOD_NS  8
`define GROUP_NS       40
`define GROUP_CLKS     (`GROUP_NS / `CLK_PERIOD_NS)
`define BITS_PER_NIB   4
`define FIRST_GAP_PHASE_BITS      64
`define SECOND_GAP_PHASE_BITS      32
`define FIRST_GAP_PHASE_NIBS      (`FIRST_GAP_PHASE_BITS / `BITS_PER_NIB)
`define SECOND_GAP_PHASE_NIBS      (`SECOND_GAP_PHASE_BITS / `BITS_PER_NIB)
`define SLOT_BITS      512
`define SLOT_NIBS      (`SLOT_BITS / `BITS_PER_NIB)
`define JAM_BITS       32
`define JAM_NIBS       (`JAM_BITS / `BITS_PER_NIB)
`define PRE_NIBS       16
`define PRE_NIB        4'h5
`define SFD_HI_NIB     4'hD
`define ADDR_BYTES     6
`define MIN_DATA_BYTES 46
`define LEN_MAX        16'h05DC
`define BACKOFF_LIMIT  4'hA
`define FCS_NIBS       8
`define CRC_INIT       32'hFFFFFFFF
`define CRC_POLY       32'hEDB88320
`define CG_J           5'h18
`define CG_K           5'h11
`define CG_T           5'h0D
`define CG_R           5'h07
`define CG_IDLE        5'h1F
`define FIFO_BYTES     2048
`endif

// ==== fem_pkg.sv ====
// Types shared by the fast Ethernet transmit MAC and its coding path.
`default_nettype none
package fem_pkg;
  typedef enum logic [3:0] {
    TX_IDLE = 4'h0, TX_DEFER1 = 4'h1, TX_DEFER2 = 4'h2, TX_PRE = 4'h3, TX_DATA = 4'h4,
    TX_PAD = 4'h5, TX_FCS = 4'h6, TX_JAM = 4'h7, TX_BACKOFF = 4'h8
  } tx_state_t;
  typedef enum logic [1:0] {
    RX_HUNT = 2'h0, RX_GOT_J = 2'h1, RX_FRAME = 2'h2, RX_GOT_T = 2'h3
  } rx_state_t;
endpackage
`default_nettype wire

// ==== fast_ethernet_mac_tx_pcs.sv ====
// Fast Ethernet MAC transmit path with 100BASE-TX coding, and the frame FIFO.
//
// Behaviour
// - Transmit FIFO of 2K bytes holds one whole frame of up to 1514 bytes; two fit only if together at most 2048 bytes.
// - Each frame starts with seven preamble bytes of 10101010b.
// - One start delimiter byte 10101011b follows the preamble.
// - Length/type up to 05DC is a length, above it a type.
// - Data is 46 to 1500 bytes; shorter only when padding is off.
// - Each frame ends with a 32-bit CRC.
// - First two preamble nibbles are replaced by /J/K/.
// - /T/R/ follows the last FCS nibble immediately.
// - Receive without /J/K/ abandons the frame and hunts again.
// - Receive without /T/R/ reports a CRC error.
// - Carrier during the 64-bit first gap phase restarts it.
// - After the 32-bit second gap phase transmit despite carrier.
// - After jam wait a whole number of slot times before retry.
// - Back-off r is uniform in 0 to 2^k-1, k = min(n,10).
// - Nibbles appear on MII lines and feed the 4B/5B encoder.
// - Idle code-groups are sent while there is nothing to send.
// - All code-groups pass a scrambler loaded with a 10-bit seed.
// - Groups serialise at 125 MHz, then NRZ to NRZI to MLT3.
`timescale 1ns/100ps
`default_nettype none
`include "fem_regs.svh"

module tx_byte_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = `FIFO_BYTES
) (
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  input  wire logic             commit,
  input  wire logic             rewind
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      wr_next;
  logic [AW:0]      rd_reg;
  logic [AW:0]      rd_next;
  logic [AW:0]      base_reg;
  logic [AW:0]      base_next;
  logic [AW:0]      used;

  // Space is released only on commit, so a frame can be replayed after a collision.
  always_comb begin
    used = wr_reg - base_reg;
    in_ready = (used != (AW+1)'(DEPTH));
    out_valid = (rd_reg != wr_reg);
    out_data = mem[rd_reg[AW-1:0]];
    wr_next = (in_valid && in_ready) ? wr_reg + 1'b1 : wr_reg;
    rd_next = rd_reg;
    if (rewind) begin
      rd_next = base_reg;
    end else if (out_valid && out_ready) begin
      rd_next = rd_reg + 1'b1;
    end
    base_next = commit ? rd_reg : base_reg;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      base_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      base_reg <= base_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (in_valid && in_ready) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module fast_ethernet_mac_tx_pcs #(
  parameter int         FIFO_DEPTH = `FIFO_BYTES,
  parameter logic [9:0] SCR_SEED   = 10'h2A5
) (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic [7:0] in_data,
  input  wire logic       in_last,
  input  wire logic       in_nopad,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic       crs_pin,
  input  wire logic       col_pin,
  input  wire logic [4:0] rx_group,
  input  wire logic       rx_group_valid,
  output logic [3:0]      mii_txd,
  output logic            mii_tx_en,
  output logic            mlt3_pos,
  output logic            mlt3_neg,
  output logic            tx_done,
  output logic            frame_is_length,
  output logic            rx_frame_ok,
  output logic            rx_crc_err
);
  localparam logic [2:0] GROUP_LAST = 3'(`GROUP_CLKS - 1);
  localparam logic [3:0] FIRST_GAP_PHASE_LAST  = 4'(`FIRST_GAP_PHASE_NIBS - 1);
  localparam logic [3:0] SECOND_GAP_PHASE_LAST  = 4'(`SECOND_GAP_PHASE_NIBS - 1);
  localparam logic [3:0] PRE_LAST   = 4'(`PRE_NIBS - 1);
  localparam logic [3:0] JAM_LAST   = 4'(`JAM_NIBS - 1);
  localparam logic [3:0] FCS_LAST   = 4'(`FCS_NIBS - 1);
  localparam logic [6:0] SLOT_LAST  = 7'(`SLOT_NIBS - 1);
  localparam logic [10:0] LEN_POS   = 11'(2 * `ADDR_BYTES);
  localparam logic [10:0] MIN_BODY  = 11'(2 * `ADDR_BYTES + 2 + `MIN_DATA_BYTES);

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [4:0] enc45(input logic [3:0] n);
    logic [4:0] t [16];
    t = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
          5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    return t[n];
  endfunction

  function automatic logic [9:0] backoff_mask(input logic [3:0] k);
    return 10'((11'h001 << k) - 11'h001);
  endfunction

  // Carrier and collision come from the line side; a change counts once stages 2 and 3 agree.
  logic [2:0] crs_sync_reg;
  logic [2:0] col_sync_reg;
  logic       crs_reg;
  logic       col_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      crs_sync_reg <= 3'h0;
      col_sync_reg <= 3'h0;
      crs_reg <= 1'b0;
      col_reg <= 1'b0;
    end else begin
      crs_sync_reg <= {crs_sync_reg[1:0], crs_pin};
      col_sync_reg <= {col_sync_reg[1:0], col_pin};
      crs_reg <= (crs_sync_reg[1] == crs_sync_reg[2]) ? crs_sync_reg[2] : crs_reg;
      col_reg <= (col_sync_reg[1] == col_sync_reg[2]) ? col_sync_reg[2] : col_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  logic [9:0] fifo_out;
  logic       fifo_valid;
  logic       fifo_rd;
  logic       commit;
  logic       rewind;

  tx_byte_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .in_data   ({in_nopad, in_last, in_data}),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_rd),
    .commit    (commit),
    .rewind    (rewind)
  );

  fem_pkg::tx_state_t state_reg, state_next;
  logic [2:0]  phase_reg, phase_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic        hi_reg, hi_next;
  logic [10:0] bytes_reg, bytes_next;
  logic [31:0] crc_reg, crc_next;
  logic        nopad_reg, nopad_next;
  logic [3:0]  attempt_reg, attempt_next;
  logic [9:0]  slots_reg, slots_next;
  logic [6:0]  slot_nib_reg, slot_nib_next;
  logic [15:0] lfsr_reg, lfsr_next;
  logic [7:0]  len_hi_reg, len_hi_next;
  logic        is_len_reg, is_len_next;
  logic [3:0]  txd_reg, txd_next;
  logic        en_reg, en_next;
  logic        done_reg, done_next;
  logic [11:0] pending_reg, pending_next;
  logic        tick;
  logic        sending;
  logic [31:0] fcs;

  // One code-group time is five clocks; the MAC moves one nibble per group.
  always_comb begin
    tick = (phase_reg == GROUP_LAST);
    phase_next = tick ? 3'h0 : phase_reg + 3'h1;
    lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    state_next = state_reg;
    cnt_next = cnt_reg;
    hi_next = hi_reg;
    bytes_next = bytes_reg;
    crc_next = crc_reg;
    nopad_next = nopad_reg;
    attempt_next = attempt_reg;
    slots_next = slots_reg;
    slot_nib_next = slot_nib_reg;
    len_hi_next = len_hi_reg;
    is_len_next = is_len_reg;
    txd_next = txd_reg;
    en_next = en_reg;
    done_next = 1'b0;
    fifo_rd = 1'b0;
    commit = 1'b0;
    rewind = 1'b0;
    fcs = ~crc_reg;
    sending = (state_reg == fem_pkg::TX_PRE) || (state_reg == fem_pkg::TX_DATA) ||
              (state_reg == fem_pkg::TX_PAD) || (state_reg == fem_pkg::TX_FCS);
    if (tick) begin
      en_next = 1'b0;
      txd_next = 4'h0;
      case (state_reg)
        fem_pkg::TX_IDLE: begin
          cnt_next = 4'h0;
          if (crs_reg) begin
            state_next = fem_pkg::TX_DEFER1;
          end else if (pending_reg != 12'h000) begin
            state_next = fem_pkg::TX_PRE;
          end
        end
        fem_pkg::TX_DEFER1: begin
          if (crs_reg) begin
            cnt_next = 4'h0;
          end else if (cnt_reg == FIRST_GAP_PHASE_LAST) begin
            cnt_next = 4'h0;
            state_next = fem_pkg::TX_DEFER2;
          end else begin
            cnt_next = cnt_reg + 4'h1;
          end
        end
        fem_pkg::TX_DEFER2: begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == SECOND_GAP_PHASE_LAST) begin
            cnt_next = 4'h0;
            // Carrier is no longer looked at here, so a waiting frame goes out.
            state_next = (pending_reg != 12'h000) ? fem_pkg::TX_PRE : fem_pkg::TX_IDLE;
          end
        end
        fem_pkg::TX_PRE: begin
          en_next = 1'b1;
          txd_next = (cnt_reg == PRE_LAST) ? `SFD_HI_NIB : `PRE_NIB;
          cnt_next = cnt_reg + 4'h1;
          bytes_next = 11'h000;
          hi_next = 1'b0;
          crc_next = `CRC_INIT;
          nopad_next = fifo_out[9];
          if (cnt_reg == PRE_LAST) begin
            state_next = fem_pkg::TX_DATA;
          end
        end
        fem_pkg::TX_DATA: begin
          en_next = 1'b1;
          txd_next = hi_reg ? fifo_out[7:4] : fifo_out[3:0];
          hi_next = ~hi_reg;
          if (hi_reg) begin
            fifo_rd = 1'b1;
            crc_next = crc_byte(crc_reg, fifo_out[7:0]);
            bytes_next = bytes_reg + 11'h001;
            if (bytes_reg == LEN_POS) begin
              len_hi_next = fifo_out[7:0];
            end
            if (bytes_reg == LEN_POS + 11'h001) begin
              is_len_next = ({len_hi_reg, fifo_out[7:0]} <= `LEN_MAX);
            end
            if (fifo_out[8]) begin
              cnt_next = 4'h0;
              state_next = (!nopad_reg && bytes_next < MIN_BODY) ?
                           fem_pkg::TX_PAD : fem_pkg::TX_FCS;
            end
          end
        end
        fem_pkg::TX_PAD: begin
          en_next = 1'b1;
          hi_next = ~hi_reg;
          if (hi_reg) begin
            crc_next = crc_byte(crc_reg, 8'h00);
            bytes_next = bytes_reg + 11'h001;
            if (bytes_next == MIN_BODY) begin
              state_next = fem_pkg::TX_FCS;
            end
          end
        end
        fem_pkg::TX_FCS: begin
          en_next = 1'b1;
          txd_next = fcs[{cnt_reg[2:0], 2'b00} +: 4];
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == FCS_LAST) begin
            cnt_next = 4'h0;
            done_next = 1'b1;
            commit = 1'b1;
            attempt_next = 4'h0;
            state_next = fem_pkg::TX_DEFER1;
          end
        end
        fem_pkg::TX_JAM: begin
          en_next = 1'b1;
          txd_next = `PRE_NIB;
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == JAM_LAST) begin
            rewind = 1'b1;
            attempt_next = (attempt_reg == `BACKOFF_LIMIT) ? attempt_reg : attempt_reg + 4'h1;
            slots_next = lfsr_reg[9:0] & backoff_mask(attempt_next);
            slot_nib_next = 7'h00;
            state_next = fem_pkg::TX_BACKOFF;
          end
        end
        fem_pkg::TX_BACKOFF: begin
          slot_nib_next = slot_nib_reg + 7'h01;
          if (slots_reg == 10'h000) begin
            cnt_next = 4'h0;
            state_next = fem_pkg::TX_DEFER1;
          end else if (slot_nib_reg == SLOT_LAST) begin
            slots_next = slots_reg - 10'h001;
          end
        end
        default: begin
          state_next = fem_pkg::TX_IDLE;
        end
      endcase
      if (sending && col_reg) begin
        // Jam starts one group later; the frame's nibble set up in this group still goes out.
        state_next = fem_pkg::TX_JAM;
        cnt_next = 4'h0;
        fifo_rd = 1'b0;
        commit = 1'b0;
        done_next = 1'b0;
        attempt_next = attempt_reg;
      end
    end
    pending_next = pending_reg + {11'h000, in_valid && in_ready && in_last} -
                   {11'h000, commit};
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= fem_pkg::TX_IDLE;
      phase_reg <= 3'h0;
      cnt_reg <= 4'h0;
      hi_reg <= 1'b0;
      bytes_reg <= 11'h000;
      crc_reg <= `CRC_INIT;
      nopad_reg <= 1'b0;
      attempt_reg <= 4'h0;
      slots_reg <= 10'h000;
      slot_nib_reg <= 7'h00;
      lfsr_reg <= 16'hACE1;
      len_hi_reg <= 8'h00;
      is_len_reg <= 1'b0;
      txd_reg <= 4'h0;
      en_reg <= 1'b0;
      done_reg <= 1'b0;
      pending_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      hi_reg <= hi_next;
      bytes_reg <= bytes_next;
      crc_reg <= crc_next;
      nopad_reg <= nopad_next;
      attempt_reg <= attempt_next;
      slots_reg <= slots_next;
      slot_nib_reg <= slot_nib_next;
      lfsr_reg <= lfsr_next;
      len_hi_reg <= len_hi_next;
      is_len_reg <= is_len_next;
      txd_reg <= txd_next;
      en_reg <= en_next;
      done_reg <= done_next;
      pending_reg <= pending_next;
    end
  end

  assign mii_txd = txd_reg;
  assign mii_tx_en = en_reg;
  assign tx_done = done_reg;
  assign frame_is_length = is_len_reg;

  ////////////////////////////////////////////////////////////////////////////////

  logic        prev_en_reg, prev_en_next;
  logic        first_reg, first_next;
  logic        tail_reg, tail_next;
  logic [4:0]  grp_reg, grp_next;
  logic [4:0]  sh_reg, sh_next;
  logic [10:0] scr_reg, scr_next;
  logic        nrzi_reg, nrzi_next;
  logic [1:0]  mlt_reg, mlt_next;
  logic        key;
  logic        scr_bit;

  // The encoder samples the MII lines one group after the MAC drives them.
  always_comb begin
    prev_en_next = prev_en_reg;
    first_next = first_reg;
    tail_next = tail_reg;
    grp_next = grp_reg;
    sh_next = {sh_reg[3:0], 1'b0};
    if (tick) begin
      prev_en_next = mii_tx_en;
      first_next = mii_tx_en && !prev_en_reg;
      tail_next = !mii_tx_en && prev_en_reg;
      if (mii_tx_en) begin
        grp_next = !prev_en_reg ? `CG_J : (first_reg ? `CG_K : enc45(mii_txd));
      end else if (prev_en_reg) begin
        grp_next = `CG_T;
      end else if (tail_reg) begin
        grp_next = `CG_R;
      end else begin
        grp_next = `CG_IDLE;
      end
      sh_next = grp_next;
    end
    key = scr_reg[10] ^ scr_reg[8];
    scr_next = {scr_reg[9:0], key};
    scr_bit = sh_reg[4] ^ key;
    nrzi_next = nrzi_reg ^ scr_bit;
    mlt_next = (nrzi_next != nrzi_reg) ? mlt_reg + 2'h1 : mlt_reg;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prev_en_reg <= 1'b0;
      first_reg <= 1'b0;
      tail_reg <= 1'b0;
      grp_reg <= `CG_IDLE;
      sh_reg <= `CG_IDLE;
      scr_reg <= {1'b1, SCR_SEED};
      nrzi_reg <= 1'b0;
      mlt_reg <= 2'h0;
      mlt3_pos <= 1'b0;
      mlt3_neg <= 1'b0;
    end else begin
      prev_en_reg <= prev_en_next;
      first_reg <= first_next;
      tail_reg <= tail_next;
      grp_reg <= grp_next;
      sh_reg <= sh_next;
      scr_reg <= scr_next;
      nrzi_reg <= nrzi_next;
      mlt_reg <= mlt_next;
      mlt3_pos <= (mlt_next == 2'h1);
      mlt3_neg <= (mlt_next == 2'h3);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  fem_pkg::rx_state_t rx_reg, rx_next;
  logic ok_next;
  logic err_next;

  always_comb begin
    rx_next = rx_reg;
    ok_next = 1'b0;
    err_next = 1'b0;
    if (rx_group_valid) begin
      case (rx_reg)
        fem_pkg::RX_HUNT: rx_next = (rx_group == `CG_J) ? fem_pkg::RX_GOT_J : rx_reg;
        fem_pkg::RX_GOT_J: begin
          rx_next = (rx_group == `CG_K) ? fem_pkg::RX_FRAME : fem_pkg::RX_HUNT;
        end
        fem_pkg::RX_FRAME: begin
          if (rx_group == `CG_T) begin
            rx_next = fem_pkg::RX_GOT_T;
          end else if (rx_group == `CG_IDLE) begin
            err_next = 1'b1;
            rx_next = fem_pkg::RX_HUNT;
          end
        end
        fem_pkg::RX_GOT_T: begin
          ok_next = (rx_group == `CG_R);
          err_next = (rx_group != `CG_R);
          rx_next = fem_pkg::RX_HUNT;
        end
        default: rx_next = fem_pkg::RX_HUNT;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_reg <= fem_pkg::RX_HUNT;
      rx_frame_ok <= 1'b0;
      rx_crc_err <= 1'b0;
    end else begin
      rx_reg <= rx_next;
      rx_frame_ok <= ok_next;
      rx_crc_err <= err_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  a_preamble_nibble: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tick && state_reg == fem_pkg::TX_PRE && cnt_reg != PRE_LAST && !col_reg
    |=> mii_tx_en && mii_txd == 4'h5) else $error("preamble nibble wrong");
  a_sfd_nibble: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tick && state_reg == fem_pkg::TX_PRE && cnt_reg == PRE_LAST && !col_reg
    |=> (mii_txd == 4'hD && state_reg == fem_pkg::TX_DATA) [*5]) else $error("start delimiter wrong");
  a_jk_start: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tick && mii_tx_en && !prev_en_reg |=> grp_reg == `CG_J ##5 grp_reg == `CG_K)
    else $error("stream start not J then K");
  a_tr_end: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tick && !mii_tx_en && prev_en_reg |=> grp_reg == `CG_T ##5 grp_reg == `CG_R)
    else $error("stream end not T then R");
  a_idle_fill: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tick && !mii_tx_en && !prev_en_reg && !tail_reg |=> grp_reg == `CG_IDLE)
    else $error("idle group missing");
  a_gap_restart: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tick && state_reg == fem_pkg::TX_DEFER1 && crs_reg |=> cnt_reg == 4'h0)
    else $error("carrier did not restart gap");
  a_gap_commit: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tick && state_reg == fem_pkg::TX_DEFER2 && cnt_reg == SECOND_GAP_PHASE_LAST && pending_reg != 12'h000
    |=> state_reg == fem_pkg::TX_PRE) else $error("second gap did not commit");
  a_backoff_range: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(state_reg == fem_pkg::TX_BACKOFF)
    |-> (slots_reg & ~backoff_mask(attempt_reg)) == 10'h000)
    else $error("back-off count out of range");
  a_jam_length: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(state_reg == fem_pkg::TX_JAM) |-> ##39 state_reg == fem_pkg::TX_JAM ##1
    state_reg == fem_pkg::TX_BACKOFF) else $error("jam not 32 bits");
  a_pad_min: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(state_reg == fem_pkg::TX_FCS) && !nopad_reg |-> bytes_reg >= MIN_BODY)
    else $error("frame shorter than minimum");
  a_missing_end: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rx_group_valid && rx_reg == fem_pkg::RX_FRAME && rx_group == `CG_IDLE |=> rx_crc_err)
    else $error("missing end not flagged");
endmodule
`default_nettype wire

// ==== remote_station.sv ====
// Remote station model: carrier sense and received code-groups.
`timescale 1ns/100ps
`default_nettype none
module remote_station (
  input  wire logic       clk_sys,
  output logic            crs_pin,
  output logic            col_pin,
  output logic [4:0]      rx_group,
  output logic            rx_group_valid
);
  initial begin
    crs_pin = 1'b0;
    col_pin = 1'b0;
    rx_group = 5'h00;
    rx_group_valid = 1'b0;
  end
  // Off the strobe the group lines flip, so a stale value is never mistaken for data.
  task automatic send_group(input logic [4:0] g);
    @(negedge clk_sys);
    rx_group = g;
    rx_group_valid = 1'b1;
    @(negedge clk_sys);
    rx_group_valid = 1'b0;
    rx_group = ~g;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic carrier(input int n);
    @(negedge clk_sys);
    crs_pin = 1'b1;
    repeat (n) @(negedge clk_sys);
    crs_pin = 1'b0;
  endtask
  task automatic collide(input int n);
    @(negedge clk_sys);
    col_pin = 1'b1;
    repeat (n) @(negedge clk_sys);
    col_pin = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== test_fast_ethernet_mac_tx_pcs.sv ====
// Self-checking bench for the transmit MAC and its coding path.
`timescale 1ns/100ps
`default_nettype none
`include "fem_regs.svh"
module test_fast_ethernet_mac_tx_pcs;
  logic       clk_sys = 1'b0, arst_n = 1'b0;
  logic [7:0] in_data = 8'h00;
  logic       in_last = 1'b0, in_nopad = 1'b0, in_valid = 1'b0;
  logic       in_ready, crs_pin, col_pin, rx_group_valid, mii_tx_en, mlt3_pos, mlt3_neg;
  logic       tx_done, frame_is_length, rx_frame_ok, rx_crc_err;
  logic [4:0] rx_group;
  logic [3:0] mii_txd;
  int         bad_count = 0, checked = 0, ok_n = 0, err_n = 0;
  int         mlt_bad = 0, mlt_moves = 0;
  logic       lp = 1'b0, ln = 1'b0;
  always #4 clk_sys = ~clk_sys;
  // MLT3 steps through zero, so the line never swings straight from one rail to the other.
  always @(negedge clk_sys) begin
    mlt_bad <= mlt_bad + int'((mlt3_pos && mlt3_neg) || (lp && mlt3_neg) || (ln && mlt3_pos));
    mlt_moves <= mlt_moves + int'({lp, ln} != {mlt3_pos, mlt3_neg});
    lp <= mlt3_pos;
    ln <= mlt3_neg;
  end
  always @(posedge clk_sys) begin
    ok_n <= ok_n + int'(rx_frame_ok === 1'b1);
    err_n <= err_n + int'(rx_crc_err === 1'b1);
  end
  remote_station peer (.clk_sys, .crs_pin, .col_pin, .rx_group, .rx_group_valid);
  fast_ethernet_mac_tx_pcs dut (.clk_sys, .arst_n, .in_data, .in_last, .in_nopad,
    .in_valid, .in_ready, .crs_pin, .col_pin, .rx_group, .rx_group_valid, .mii_txd,
    .mii_tx_en, .mlt3_pos, .mlt3_neg, .tx_done, .frame_is_length, .rx_frame_ok, .rx_crc_err);
  task automatic check(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      bad_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic put_frame(input int n, input logic [15:0] lt, input logic nopad);
    int t;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      in_valid = 1'b1;
      in_nopad = nopad;
      in_last = (i == n - 1);
      in_data = (i == 12) ? lt[15:8] : (i == 13) ? lt[7:0] : 8'(i + 'h21);
      t = 0;
      while (in_ready !== 1'b1 && t < 100) begin
        @(negedge clk_sys);
        t++;
      end
      check(t < 100, "input stalled");
    end
    @(negedge clk_sys);
    in_valid = 1'b0;
  endtask
  // Counts negedges with the enable high; nibble k is sampled in mid-slot.
  task automatic observe(input int nibs, input logic isl, output int w);
    int c;
    logic [3:0] e;
    logic d;
    w = 0;
    c = 0;
    d = 1'b0;
    while (mii_tx_en !== 1'b1 && w < 4000) begin
      @(negedge clk_sys);
      w++;
    end
    check(w < 4000, "no frame start");
    if (w == 4000) tally_and_finish;
    while (mii_tx_en === 1'b1 && c < 9000) begin
      e = (c < 75) ? 4'h5 : (c < 80) ? `SFD_HI_NIB : (c < 85) ? 4'h1 : 4'h2;
      if (c % 5 == 2 && c < 90)
        check(mii_txd === e, "nibble");
      @(negedge clk_sys);
      d |= (tx_done === 1'b1);
      c++;
    end
    repeat (5) begin
      @(negedge clk_sys);
      d |= (tx_done === 1'b1);
    end
    check(c == nibs * 5, "frame length");
    check(d, "no done");
    check(frame_is_length === isl, "length/type");
  endtask
  task automatic test_tx;
    int w;
    // Carrier holds the MAC back until both frames sit in the FIFO.
    fork
      peer.carrier(70);
      begin
        repeat (8) @(negedge clk_sys);
        put_frame(20, 16'h05DC, 1'b1);
        put_frame(24, 16'h05DD, 1'b0);
      end
    join
    observe(64, 1'b1, w);
    check(w >= 120, "gap too short");
    observe(144, 1'b0, w);
    check(w >= 110, "back-to-back gap");
    check(mlt_bad == 0 && mlt_moves > 10, "line coding");
    $display("test_tx done");
  endtask
  // A collision early in the preamble cuts the frame; the same frame must follow.
  task automatic test_col;
    int w, c;
    logic [3:0] e;
    logic d;
    put_frame(20, 16'h0800, 1'b1);
    w = 0;
    c = 0;
    d = 1'b0;
    e = 4'h0;
    while (mii_tx_en !== 1'b1 && w < 4000) begin
      @(negedge clk_sys);
      w++;
    end
    peer.collide(10);
    while (mii_tx_en === 1'b1 && c < 400) begin
      e = mii_txd;
      d |= (tx_done === 1'b1);
      @(negedge clk_sys);
      c++;
    end
    check(c >= 38 && c <= 46 && e === `PRE_NIB && !d, "jam");
    observe(64, 1'b0, w);
    check(w >= 120 && w <= 770, "back-off delay");
    $display("test_col done");
  endtask
  task automatic rx_seq(input logic [29:0] s, input int dok, input int derr);
    int o, e;
    o = ok_n;
    e = err_n;
    for (int i = 5; i >= 0; i--) peer.send_group(s[i*5+:5]);
    check(ok_n == o + dok && err_n == e + derr, "rx verdict");
  endtask
  task automatic test_rx;
    rx_seq({`CG_J, `CG_K, 5'h0E, 5'h0E, `CG_T, `CG_R}, 1, 0);
    rx_seq({`CG_J, 5'h0E, 5'h0E, `CG_T, `CG_R, `CG_IDLE}, 0, 0);
    rx_seq({`CG_J, `CG_K, 5'h0E, `CG_IDLE, `CG_IDLE, `CG_IDLE}, 0, 1);
    rx_seq({`CG_J, `CG_K, `CG_T, 5'h0E, `CG_IDLE, `CG_IDLE}, 0, 1);
    $display("test_rx done");
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    arst_n = 1'b1;
    test_tx;
    test_col;
    test_rx;
    tally_and_finish;
  end
endmodule
`default_nettype wire
